//--- src/chrc_core_halt_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Leave debug halt only after both debugger and multi-core controller released it.
// - Acknowledge multi-core halt even when already debug halted.
// - Multi-core run during a busy debugger operation keeps the core halted.
// - Debugger resume with multi-core halt outstanding keeps in-debug asserted.
// - Enter running, drop in-debug, then acknowledge the run request.
// - Power halt wakes on run request, top irq, timers or NMI.
// - Firmware halt quiesces the core before reporting graceful halt.
// - DMA stays serviced in both halted states.
// - Halted core ignores lower irqs; top irq needs both enables.
// - Pending irqs are serviced once running again.
// - Reserved control bits read zero; writes ignored.
// - Writing halt bit starts power halt; reads zero; ignored in debug.
// - Halt-irq-enable resets to one and sets global enable on a firmware halt.
// - Writing only halt-irq-enable leaves global enable unchanged.
// - Global enable set on halt entry stays set after exit.
// - In debug, halt-irq-enable writes never change the global enable.
// - Multi-core run uses a four-phase request and acknowledge handshake.
// - Start-state input selects running or debug halted out of reset.
module chrc_core_halt_ctrl (
    // Clock and reset.
    input  wire logic                    clock,
    input  wire logic                    reset,
    // Start state, already synchronous to the core clock.
    input  wire logic                    reset_run_req,
    // CSR port from the pipeline.
    input  wire chrc_pkg::chrc_csr_req_t csr_req,
    output logic [31:0]                  csr_rdata,
    output logic                         csr_hit,
    // Core debugger.
    input  wire logic                    dbg_halt_req,
    input  wire logic                    dbg_resume_req,
    input  wire logic                    dbg_busy,
    // Multi-core debug controller.
    input  wire logic                    mc_halt_req,
    output logic                         mc_halt_ack,
    input  wire logic                    mc_run_req,
    output logic                         mc_run_ack,
    output logic                         debug_mode_status,
    // Power unit and wake sources.
    input  wire logic                    pmu_halt_req,
    input  wire chrc_pkg::chrc_wake_t    wake,
    input  wire logic                    irq_pending,
    input  wire logic                    pipe_idle,
    // Interrupt enables of the core.
    input  wire logic                    meie,
    input  wire logic                    mie_in,
    input  wire logic                    mie_wr_en,
    input  wire logic                    mie_wr_val,
    output logic                         mie,
    // Core activity.
    output logic                         core_run,
    output logic                         core_halted,
    output logic                         irq_take,
    output logic                         dma_enable
);
    import chrc_pkg::*;

    chrc_state_t state_q;
    chrc_state_t state_d;
    logic        hie_q;
    logic        hie_d;
    logic        mie_q;
    logic        mie_d;
    logic        run_ack_q;
    logic        run_ack_d;
    logic        halt_ack_q;
    logic        halt_ack_d;
    logic        started_q;
    logic [3:0]  quiesce_cnt_q;
    logic [3:0]  quiesce_cnt_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    logic dbg_owner;
    logic mc_owner;
    logic exit_ok;
    logic in_debug;
    logic pmc_sel;
    logic pmc_wr;
    logic fw_halt;
    logic halt_start;
    logic wake_any;
    logic quiesced;

    // Shared decode of the register address.
    function automatic logic pmc_match(input logic [11:0] a);
        pmc_match = (a == CHRC_PMC_ADDR);
    endfunction : pmc_match

    chrc_debug_arb u_arb (
        .clock          (clock),
        .reset          (reset),
        .dbg_halt_req   (dbg_halt_req),
        .dbg_resume_req (dbg_resume_req),
        .dbg_busy       (dbg_busy),
        .mc_halt_req    (mc_halt_req | (~started_q & ~reset_run_req)),
        .mc_run_req     (mc_run_req),
        .in_debug       (in_debug),
        .dbg_owner      (dbg_owner),
        .mc_owner       (mc_owner),
        .exit_ok        (exit_ok)
    );

    // Register decode and write strobes.
    assign in_debug   = (state_q == CHRC_DBG_HALT);
    assign pmc_sel    = pmc_match(csr_req.addr);
    assign pmc_wr     = csr_req.wr_en & pmc_sel;
    assign fw_halt    = pmc_wr & csr_req.wdata[CHRC_PMC_HALT_BIT] & ~in_debug;
    assign halt_start = (state_q == CHRC_RUNNING) & (fw_halt | pmu_halt_req);
    assign quiesced   = pipe_idle & (quiesce_cnt_q == 4'h0);

    // Top irq wakes only with both enables; lower irqs are not looked at here.
    assign wake_any = wake.pmu_run | (wake.irq_top & mie_q & meie) | wake.timer
                    | wake.int_timer | wake.nmi;

    // Halt-enable stores any written value; reserved bits are never stored.
    assign hie_d = pmc_wr ? csr_req.wdata[CHRC_PMC_HIE_BIT] : hie_q;

    // Global enable: atomic set only on a real halt start, never from a debug write.
    always_comb begin
        mie_d = mie_q;
        if (mie_wr_en) begin
            mie_d = mie_wr_val;
        end else if (mie_in != mie_q && !halt_start) begin
            mie_d = mie_in;
        end
        // A debug halt in the same cycle wins over the power halt. The enable must not
        // change then, because no halt transition takes place.
        if (fw_halt && halt_start && !dbg_halt_req && !mc_halt_req && hie_d) begin
            mie_d = 1'b1;
        end
    end

    // Activity state machine.
    always_comb begin
        state_d       = state_q;
        quiesce_cnt_d = quiesce_cnt_q;
        case (state_q)
            CHRC_RUNNING: begin
                if (dbg_halt_req || mc_halt_req) begin
                    state_d = CHRC_DBG_HALT;
                end else if (halt_start) begin
                    state_d       = CHRC_QUIESCE;
                    quiesce_cnt_d = CHRC_QUIESCE_CYC_W;
                end
            end
            CHRC_QUIESCE: begin
                if (quiesce_cnt_q != 4'h0) begin
                    quiesce_cnt_d = quiesce_cnt_q - 4'h1;
                end
                // A debug halt during the drain goes straight to debug halt, so its ack is not lost.
                if (dbg_halt_req || mc_halt_req) begin
                    state_d = CHRC_DBG_HALT;
                end else if (quiesced) begin
                    state_d = CHRC_PWR_HALT;
                end
            end
            CHRC_PWR_HALT: begin
                if (dbg_halt_req || mc_halt_req) begin
                    state_d = CHRC_DBG_HALT;
                end else if (wake_any) begin
                    state_d = CHRC_RUNNING;
                end
            end
            CHRC_DBG_HALT: begin
                if (exit_ok && !dbg_halt_req && !mc_halt_req) begin
                    state_d = CHRC_RUNNING;
                end
            end
            default: begin
                state_d = CHRC_RUNNING;
            end
        endcase
    end

    // Halt ack follows the request, also when already halted by the debugger.
    assign halt_ack_d = mc_halt_req & (in_debug | (state_d == CHRC_DBG_HALT));
    // Run ack rises only a cycle after running, held until the request drops.
    assign run_ack_d  = mc_run_req & (state_q == CHRC_RUNNING) & ~debug_mode_status;

    // Read data from a register; reserved bits and the halt bit read zero.
    always_comb begin
        rdata_d = 32'h0;
        if (csr_req.rd_en && pmc_sel) begin
            rdata_d[CHRC_PMC_HIE_BIT] = hie_q;
        end
    end

    // Start state: sampled once at the first edge after reset release.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            started_q <= 1'b0;
        end else begin
            started_q <= 1'b1;
        end
    end

    // Main state registers.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q       <= CHRC_RUNNING;
            quiesce_cnt_q <= 4'h0;
        end else if (!started_q) begin
            state_q       <= reset_run_req ? CHRC_RUNNING : CHRC_DBG_HALT;
            quiesce_cnt_q <= 4'h0;
        end else begin
            state_q       <= state_d;
            quiesce_cnt_q <= quiesce_cnt_d;
        end
    end

    // Control register and handshake flops.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            hie_q      <= CHRC_PMC_HIE_RESET;
            mie_q      <= 1'b0;
            run_ack_q  <= 1'b0;
            halt_ack_q <= 1'b0;
            rdata_q    <= 32'h0;
        end else begin
            hie_q      <= hie_d;
            mie_q      <= mie_d;
            run_ack_q  <= run_ack_d;
            halt_ack_q <= halt_ack_d;
            rdata_q    <= rdata_d;
        end
    end

    // Status outputs. Debug status drops the cycle the core runs, ack comes a cycle later.
    always_comb begin
        debug_mode_status = in_debug | ~started_q;
    end

    assign mc_run_ack  = run_ack_q;
    assign mc_halt_ack = halt_ack_q;
    assign csr_rdata   = rdata_q;
    assign csr_hit     = pmc_sel & (csr_req.rd_en | csr_req.wr_en);
    assign mie         = mie_q;
    assign core_run    = (state_q == CHRC_RUNNING) & started_q;
    assign core_halted = (state_q == CHRC_PWR_HALT) | in_debug;
    // Interrupts are only taken while running; pending ones wait for the return.
    assign irq_take    = core_run & irq_pending & mie_q & meie;
    // DMA keeps running whatever the activity state.
    assign dma_enable  = 1'b1;

    // Unused dbg and mc owner status is kept for debug visibility.
    logic owners_unused;
    assign owners_unused = dbg_owner & mc_owner;

endmodule : chrc_core_halt_ctrl

//--- src/chrc_debug_arb.sv
`timescale 1ns/1ps
module chrc_debug_arb (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic reset,
    // Debug requests.
    input  wire logic dbg_halt_req,
    input  wire logic dbg_resume_req,
    input  wire logic dbg_busy,
    input  wire logic mc_halt_req,
    input  wire logic mc_run_req,
    input  wire logic in_debug,
    // Owner status.
    output logic      dbg_owner,
    output logic      mc_owner,
    output logic      exit_ok
);
    import chrc_pkg::*;

    logic dbg_owner_q;
    logic dbg_owner_d;
    logic mc_owner_q;
    logic mc_owner_d;

    // Each party holds the core halted until it releases it; halt wins a same-cycle release.
    assign dbg_owner_d = dbg_halt_req | (dbg_owner_q & ~(dbg_resume_req & ~dbg_busy));
    assign mc_owner_d  = mc_halt_req | (mc_owner_q & ~mc_run_req & in_debug);
    // Leaving needs both owners released, in any order.
    assign exit_ok     = ~dbg_owner_q & ~mc_owner_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dbg_owner_q <= 1'b0;
            mc_owner_q  <= 1'b0;
        end else begin
            dbg_owner_q <= dbg_owner_d;
            mc_owner_q  <= mc_owner_d;
        end
    end

    assign dbg_owner = dbg_owner_q;
    assign mc_owner  = mc_owner_q;

endmodule : chrc_debug_arb

//--- src/chrc_pkg.sv
package chrc_pkg;

    // CSR address of the power management control register.
    localparam logic [11:0] CHRC_PMC_ADDR      = 12'h7C6;
    // Field positions and reset values.
    localparam int          CHRC_PMC_HALT_BIT  = 0;
    localparam int          CHRC_PMC_HIE_BIT   = 1;
    localparam logic        CHRC_PMC_HIE_RESET = 1'h1;
    // Cycles the core pipeline needs to drain before a graceful halt is reported.
    localparam int          CHRC_QUIESCE_NS     = 100;
    localparam int          CHRC_CLK_NS         = 20;
    localparam int          CHRC_QUIESCE_CYC    = (CHRC_QUIESCE_NS + CHRC_CLK_NS - 1) / CHRC_CLK_NS;
    localparam logic [3:0]  CHRC_QUIESCE_CYC_W  = 4'(CHRC_QUIESCE_CYC);

    // Activity states, Gray coded along run -> quiesce -> power halt.
    typedef enum logic [1:0] {
        CHRC_RUNNING   = 2'h0,
        CHRC_QUIESCE   = 2'h1,
        CHRC_PWR_HALT  = 2'h3,
        CHRC_DBG_HALT  = 2'h2
    } chrc_state_t;

    // CSR access from the core pipeline.
    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        logic [11:0] addr;
        logic [31:0] wdata;
    } chrc_csr_req_t;

    // Wake-up sources seen while power halted.
    typedef struct packed {
        logic pmu_run;
        logic irq_top;
        logic timer;
        logic int_timer;
        logic nmi;
    } chrc_wake_t;

endpackage : chrc_pkg

//--- tb/chrc_checker.sv
`timescale 1ns/1ps
module chrc_checker
    import chrc_pkg::*;
(
    // Clock and reset.
    input wire logic          clock,
    input wire logic          reset,
    // Register port.
    input wire chrc_csr_req_t csr_req,
    input wire logic [31:0]   csr_rdata,
    // Debug handshakes.
    input wire logic          dbg_busy,
    input wire logic          mc_halt_req,
    input wire logic          mc_halt_ack,
    input wire logic          mc_run_req,
    input wire logic          mc_run_ack,
    input wire logic          debug_mode_status,
    // Wake and activity.
    input wire chrc_wake_t    wake,
    input wire logic          meie,
    input wire logic          mie,
    input wire logic          core_run,
    input wire logic          core_halted,
    input wire logic          dma_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // Firmware halt write, and the halted state outside debug.
    wire fw_halt  = csr_req.wr_en && csr_req.addr == CHRC_PMC_ADDR
                    && csr_req.wdata[CHRC_PMC_HALT_BIT];
    wire pwr_halt = core_halted && !debug_mode_status;

    // Relations other than a_rdata and a_dma tie an output to its cause by cycle count; quiesce checks only five of the six drain cycles.
    property p_halt_ack; mc_halt_req |=> mc_halt_ack; endproperty
    a_halt_ack: assert property (p_halt_ack) else $error("halt not acked");
    property p_ack_fall; !mc_run_req |=> !mc_run_ack; endproperty
    a_ack_fall: assert property (p_ack_fall) else $error("run ack unrequested");
    property p_run_late; $rose(mc_run_ack) |-> !$past(debug_mode_status); endproperty
    a_run_late: assert property (p_run_late) else $error("run ack too early");
    property p_busy; dbg_busy && debug_mode_status |=> debug_mode_status; endproperty
    a_busy: assert property (p_busy) else $error("left debug while busy");
    property p_quiesce; fw_halt && core_run && !debug_mode_status |=> !core_halted [*5]; endproperty
    a_quiesce: assert property (p_quiesce) else $error("halted unquiesced");
    property p_irq_gate; pwr_halt && !(mie && meie) && wake == 5'h08 |=> core_halted; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("woke on masked irq");
    property p_rdata; csr_rdata[31:2] == 30'h0 && !csr_rdata[0]; endproperty
    a_rdata: assert property (p_rdata) else $error("read-zero bit set");
    property p_dma; dma_enable; endproperty
    a_dma: assert property (p_dma) else $error("dma blocked");

    // Main scenarios reached.
    c_run_ack: cover property ($rose(mc_run_ack));
    c_pwr: cover property (pwr_halt);
    c_busy: cover property (dbg_busy && mc_run_req);
endmodule : chrc_checker

//--- tb/chrc_mc_model.sv
`timescale 1ns/1ps
module chrc_mc_model (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic reset,
    // Bench commands; slow holds a request one extra cycle.
    input  wire logic halt_go,
    input  wire logic run_go,
    input  wire logic slow,
    // Handshake with the core.
    output logic      mc_halt_req,
    input  wire logic mc_halt_ack,
    output logic      mc_run_req,
    input  wire logic mc_run_ack
);
    // A request falls only once its acknowledge has been seen.
    logic halt_seen_q;
    logic run_seen_q;
    wire  halt_drop = mc_halt_ack && (!slow || halt_seen_q);
    wire  run_drop  = mc_run_ack && (!slow || run_seen_q);

    // Requests rise on a command and hold until acknowledged.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mc_halt_req <= 1'h0;
            mc_run_req  <= 1'h0;
            halt_seen_q <= 1'h0;
            run_seen_q  <= 1'h0;
        end else begin
            halt_seen_q <= mc_halt_ack;
            run_seen_q  <= mc_run_ack;
            mc_halt_req <= halt_go || (mc_halt_req && !halt_drop);
            mc_run_req  <= run_go || (mc_run_req && !run_drop);
        end
    end
endmodule : chrc_mc_model

//--- tb/test_core_halt_run_control.sv
`timescale 1ns/1ps
module test_core_halt_run_control;
    import chrc_pkg::*;
    // Stimulus; pul strobes debug halt, resume, mc halt, mc run and mie clear.
    logic          clock         = 1'h0;
    logic          reset         = 1'h1;
    logic          reset_run_req = 1'h1;
    chrc_csr_req_t csr_req       = '0;
    logic [4:0]    pul           = 5'h00;
    logic          dbg_busy      = 1'h0;
    logic          slow          = 1'h0;
    chrc_wake_t    wake          = '0;
    logic          irq_pending   = 1'h0;
    logic          meie          = 1'h1;
    // Outputs and counters.
    logic [31:0]   csr_rdata;
    logic          csr_hit, mc_halt_req, mc_halt_ack, mc_run_req, mc_run_ack;
    logic          debug_mode_status, mie, core_run, core_halted, irq_take;
    int            failures = 0;
    int            checks   = 0;
    int            cycles   = 0;
    wire  [4:0]    sts = {mc_halt_ack, debug_mode_status, mc_run_ack, core_halted, core_run};

    // Core clock.
    always #10 clock = ~clock;

    chrc_core_halt_ctrl DUT (.clock, .reset, .reset_run_req, .csr_req, .csr_rdata, .csr_hit,
        .dbg_halt_req(pul[0]), .dbg_resume_req(pul[1]), .dbg_busy, .mc_halt_req, .mc_halt_ack,
        .mc_run_req, .mc_run_ack, .debug_mode_status, .pmu_halt_req(1'h0), .wake, .irq_pending,
        .pipe_idle(1'h1), .meie, .mie_in(mie), .mie_wr_en(pul[4]), .mie_wr_val(1'h0), .mie,
        .core_run, .core_halted, .irq_take, .dma_enable());
    chrc_mc_model u_mc (.clock, .reset, .halt_go(pul[2]), .run_go(pul[3]), .slow,
        .mc_halt_req, .mc_halt_ack, .mc_run_req, .mc_run_ack);

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic pulse(input int i);
        pul[i] = 1'h1;
        tick();
        pul[i] = 1'h0;
    endtask : pulse
    // Read data lands one cycle after the request; only the mapped address hits.
    task automatic csr_rd(input logic [11:0] a, input logic [31:0] exp);
        csr_req = '{1'h0, 1'h1, a, 32'h0};
        #2;
        check(32'(csr_hit), 32'(a == CHRC_PMC_ADDR));
        tick();
        csr_req = '0;
        if (a == CHRC_PMC_ADDR) check(csr_rdata, exp);
        tick();
    endtask : csr_rd
    task automatic csr_wr(input logic [31:0] d);
        csr_req = '{1'h1, 1'h0, CHRC_PMC_ADDR, d};
        tick();
        csr_req = '0;
        tick();
    endtask : csr_wr
    // Bounded poll, so a stuck design cannot hang the run.
    task automatic wait_bit(input int i, input logic v);
        int n = 0;
        while (sts[i] !== v && n < 40) begin
            tick();
            n++;
        end
        check(32'(sts[i]), 32'(v));
    endtask : wait_bit
    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // Hang guard, far above the under two hundred cycles needed.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            complete_run();
        end
    end

    // Main sequence.
    initial begin
        tick(8);
        reset = 1'h0;
        tick(2);
        check(32'(debug_mode_status), 32'h0);
        csr_rd(CHRC_PMC_ADDR, 32'h2);
        csr_rd(12'h7C2, 32'h0);
        csr_wr(32'hFFFF_FFFC);
        csr_rd(CHRC_PMC_ADDR, 32'h0);
        csr_wr(32'h2);
        check(32'(mie), 32'h0);
        for (int i = 0; i < 5; i++) begin
            pulse(4);
            csr_wr(32'h3);
            wait_bit(1, 1'h1);
            check(32'(mie), 32'h1);
            wake = chrc_wake_t'(5'h01 << i);
            wait_bit(0, 1'h1);
            wake = '0;
            check(32'(mie), 32'h1);
        end
        meie = 1'h0;
        csr_wr(32'h3);
        wait_bit(1, 1'h1);
        wake.irq_top = 1'h1;
        tick(6);
        check(32'(core_halted), 32'h1);
        meie = 1'h1;
        wake = chrc_wake_t'(5'h18);
        wait_bit(0, 1'h1);
        wake = '0;
        irq_pending = 1'h1;
        tick();
        check(32'(irq_take), 32'h1);
        irq_pending = 1'h0;
        csr_rd(CHRC_PMC_ADDR, 32'h2);
        $display("test power halt done");
        // Run while busy first, then resume before run.
        for (int k = 0; k < 2; k++) begin
            slow = (k == 0);
            pulse(0);
            wait_bit(3, 1'h1);
            pulse(2);
            wait_bit(4, 1'h1);
            pulse(4);
            csr_wr(32'h3);
            dbg_busy = (k == 0);
            pulse(k == 0 ? 3 : 1);
            tick(6);
            check(32'(debug_mode_status), 32'h1);
            check(32'(mie), 32'h0);
            dbg_busy = 1'h0;
            pulse(k == 0 ? 1 : 3);
            wait_bit(2, 1'h1);
            tick(8);
            check(32'(core_run), 32'h1);
        end
        $display("test debug done");
        reset = 1'h1;
        reset_run_req = 1'h0;
        tick(2);
        reset = 1'h0;
        tick(3);
        check(32'(debug_mode_status), 32'h1);
        pulse(3);
        wait_bit(0, 1'h1);
        $display("test restart done");
        complete_run();
    end
endmodule : test_core_halt_run_control

bind chrc_core_halt_ctrl chrc_checker u_chk (.clock, .reset, .csr_req, .csr_rdata, .dbg_busy,
    .mc_halt_req, .mc_halt_ack, .mc_run_req, .mc_run_ack, .debug_mode_status, .wake, .meie,
    .mie, .core_run, .core_halted, .dma_enable);
